// ### sim/testbench.sv
// Self-checking bench for the error-check setup block.
`timescale 1ns/1ps
module testbench;
	logic       clk;
	logic       rst_n;
	logic       cmdSclk;
	logic       serialCmdBits;
	logic       cmdSelect_n;
	logic [3:0] acqMode;
	logic       acqByteValid;
	logic [5:0] acqByteIndex;
	logic       acqByteError;
	logic [7:0] acqByteData;
	logic       bufWrite;
	logic       bufError;
	logic [7:0] bufData;
	logic       runinDiscrimSel;
	logic       framingDiscrimSel;
	int         errCount;
	int         nTests;
	logic [5:0] parBase [8] = '{6'h26, 6'h16, 6'h1E, 6'h0E, 6'h1A, 6'h24, 6'h1A, 6'h24};

	tvecs_top uut (.clk(clk), .rst_n(rst_n), .cmdSclk(cmdSclk), .serialCmdBits(serialCmdBits),
		.cmdSelect_n(cmdSelect_n), .acqMode(acqMode), .acqByteValid(acqByteValid),
		.acqByteIndex(acqByteIndex), .acqByteError(acqByteError), .acqByteData(acqByteData),
		.bufWrite(bufWrite), .bufError(bufError), .bufData(bufData),
		.runinDiscrimSel(runinDiscrimSel), .framingDiscrimSel(framingDiscrimSel));

	tvecs_host_model host (.cmdSclk(cmdSclk), .serialCmdBits(serialCmdBits), .cmdSelect_n(cmdSelect_n));

	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check1(input string name, input logic exp, input logic got);
		nTests++;
		if (got !== exp) begin
			errCount++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
		nTests++;
		if (got !== exp) begin
			errCount++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic printVerdict();
		$display("comparisons %0d mismatches %0d", nTests, errCount);
		if (errCount == 0 && nTests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Settings land a few clocks after the last link edge, so ten clocks leave margin.
	task automatic cmd(input logic [7:0] first, input logic [7:0] setting);
		host.send_frame(first, setting, 1'h1);
		repeat (10) @(negedge clk);
	endtask

	task automatic discSel(input logic expRunin, input logic expFraming);
		check1("runinDiscrimSel", expRunin, runinDiscrimSel);
		check1("framingDiscrimSel", expFraming, framingDiscrimSel);
	endtask

	// Offers one byte, judges the write pulse one cycle later and that it lasts a single cycle.
	task automatic offer(input logic [5:0] idx, input logic err, input logic expW, input logic expE);
		logic [7:0] d;
		d = {2'h2, idx};
		acqByteValid = 1'h1;
		acqByteIndex = idx;
		acqByteError = err;
		acqByteData = d;
		@(negedge clk);
		acqByteValid = 1'h0;
		check1("bufWrite", expW, bufWrite);
		check1("bufError", expE, bufError);
		check8("bufData", d, bufData);
		@(negedge clk);
		check1("bufWrite", 1'h0, bufWrite);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_after_reset();
		discSel(1'h0, 1'h0);
		acqMode = tvecs_pkg::MODE_VPS;
		offer(6'h0B, 1'h1, 1'h0, 1'h1);
		offer(6'h0B, 1'h0, 1'h1, 1'h0);
		offer(6'h03, 1'h1, 1'h0, 1'h1);
	endtask

	task automatic t_disc();
		cmd(tvecs_pkg::CMD_DISC_MODE, 8'h18);
		discSel(1'h1, 1'h1);
		host.send_frame(8'h00, 8'h00, 1'h0);
		repeat (10) @(negedge clk);
		discSel(1'h1, 1'h1);
		// A different first byte between a command and its settings byte must cancel the command.
		host.send_frame(tvecs_pkg::CMD_DISC_MODE, 8'h00, 1'h0);
		repeat (10) @(negedge clk);
		host.send_frame(8'hF5, 8'h00, 1'h1);
		repeat (10) @(negedge clk);
		discSel(1'h1, 1'h1);
		cmd(tvecs_pkg::CMD_DISC_MODE, 8'h08);
		discSel(1'h0, 1'h1);
	endtask

	task automatic t_vps_mask();
		cmd(tvecs_pkg::CMD_DISC_MODE, 8'h02);
		cmd(tvecs_pkg::CMD_BIPH_MASK, 8'h21);
		discSel(1'h0, 1'h0);
		offer(6'h0F, 1'h1, 1'h1, 1'h0);
		offer(6'h0E, 1'h1, 1'h0, 1'h1);
		offer(6'h05, 1'h1, 1'h1, 1'h0);
		offer(6'h0B, 1'h1, 1'h0, 1'h1);
		offer(6'h10, 1'h1, 1'h0, 1'h1);
	endtask

	task automatic t_unused();
		cmd(tvecs_pkg::CMD_DISC_MODE, 8'h03);
		offer(6'h03, 1'h1, 1'h1, 1'h0);
		offer(6'h0A, 1'h1, 1'h1, 1'h0);
		acqMode = tvecs_pkg::MODE_PDC;
		offer(6'h07, 1'h1, 1'h1, 1'h1);
		offer(6'h0C, 1'h1, 1'h1, 1'h1);
		offer(6'h06, 1'h1, 1'h0, 1'h1);
		acqMode = tvecs_pkg::MODE_HDR3;
		offer(6'h15, 1'h1, 1'h1, 1'h1);
		acqMode = tvecs_pkg::MODE_STAT4;
		offer(6'h23, 1'h1, 1'h1, 1'h1);
		offer(6'h06, 1'h1, 1'h0, 1'h1);
		cmd(tvecs_pkg::CMD_DISC_MODE, 8'h02);
		offer(6'h23, 1'h1, 1'h0, 1'h1);
		acqMode = tvecs_pkg::MODE_PDC;
		offer(6'h07, 1'h1, 1'h0, 1'h1);
	endtask

	task automatic t_hamming();
		cmd(tvecs_pkg::CMD_HAM_LOW, 8'h41);
		cmd(tvecs_pkg::CMD_HAM_HIGH, 8'h28);
		acqMode = tvecs_pkg::MODE_PDC;
		offer(6'h13, 1'h1, 1'h1, 1'h1);
		offer(6'h12, 1'h1, 1'h0, 1'h1);
		offer(6'h0D, 1'h1, 1'h1, 1'h1);
		offer(6'h19, 1'h1, 1'h1, 1'h1);
		offer(6'h18, 1'h1, 1'h0, 1'h1);
		offer(6'h17, 1'h1, 1'h1, 1'h1);
		acqMode = 4'h2;
		offer(6'h13, 1'h1, 1'h0, 1'h1);
		for (int m = 0; m < 8; m++) begin
			acqMode = 4'h4 + 4'(m);
			offer(parBase[m], 1'h1, 1'h1, 1'h1);
			offer(parBase[m] + 6'h01, 1'h1, 1'h0, 1'h1);
		end
	endtask

	task automatic t_global_off();
		cmd(tvecs_pkg::CMD_DISC_MODE, 8'h04);
		acqMode = tvecs_pkg::MODE_VPS;
		offer(6'h0E, 1'h1, 1'h0, 1'h1);
		offer(6'h0F, 1'h1, 1'h1, 1'h1);
		offer(6'h10, 1'h1, 1'h1, 1'h1);
		offer(6'h03, 1'h0, 1'h1, 1'h0);
	endtask

	task automatic t_mid_reset();
		cmd(tvecs_pkg::CMD_DISC_MODE, 8'h18);
		rst_n = 1'h0;
		repeat (2) @(negedge clk);
		discSel(1'h0, 1'h0);
		rst_n = 1'h1;
		repeat (2) @(negedge clk);
		discSel(1'h0, 1'h0);
		offer(6'h0F, 1'h1, 1'h0, 1'h1);
		acqMode = tvecs_pkg::MODE_PDC;
		offer(6'h13, 1'h1, 1'h0, 1'h1);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		errCount = 0;
		nTests = 0;
		rst_n = 1'h0;
		acqMode = 4'h0;
		acqByteValid = 1'h0;
		acqByteIndex = 6'h00;
		acqByteError = 1'h0;
		acqByteData = 8'h00;
		repeat (8) @(negedge clk);
		rst_n = 1'h1;
		repeat (4) @(negedge clk);
		t_after_reset();
		t_disc();
		t_vps_mask();
		t_unused();
		t_hamming();
		t_global_off();
		t_mid_reset();
		printVerdict();
	end

	// Thirteen frames of up to some 1.5 us each plus the byte offers fit well inside this span.
	initial begin
		#300000;
		errCount++;
		printVerdict();
	end
endmodule

// ### sim/tvecs_host_model.sv
// Host model that shifts setup commands into the serial command pins.
`timescale 1ns/1ps
module tvecs_host_model (
	// Serial command pins
	output logic cmdSclk,
	output logic serialCmdBits,
	output logic cmdSelect_n
);
	initial begin
		cmdSclk = 1'h1;
		serialCmdBits = 1'h1;
		cmdSelect_n = 1'h1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bits go out MSB first and change while the link clock is low, so each rising edge sees settled data.
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			cmdSclk = 1'h0;
			serialCmdBits = b[i];
			#40;
			cmdSclk = 1'h1;
			#40;
		end
	endtask

	// The link clock stands high between frames and the released data line shows the inverse of its last bit.
	task automatic send_frame(input logic [7:0] first, input logic [7:0] setting, input logic two);
		cmdSelect_n = 1'h0;
		#40;
		send_byte(first);
		if (two) begin
			send_byte({1'h0, setting[6:0]});
		end
		#40;
		cmdSelect_n = 1'h1;
		serialCmdBits = ~serialCmdBits;
	endtask
endmodule

// ### src/tvecs_byte_gate.sv
// Per-byte hold or write decision for the readout buffer.
`timescale 1ns/1ps
module tvecs_byte_gate (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Settings and byte stream
	tvecs_if.gate    bus
);

	logic       mapped;
	logic       maskBit;
	logic       unused;
	logic       checkOn;
	logic       writeD;
	logic       errD;
	logic [5:0] parOff;

	function automatic logic isUnused(input logic [3:0] m, input logic [5:0] i);
		logic inVps;
		inVps = (i == tvecs_pkg::VPS_UNUSED_A) || (i == tvecs_pkg::VPS_UNUSED_B) ||
			(i >= tvecs_pkg::VPS_UNUSED_LO && i <= tvecs_pkg::VPS_UNUSED_HI);
		case (m)
			tvecs_pkg::MODE_VPS:  isUnused = inVps;
			tvecs_pkg::MODE_PDC:  isUnused = i >= tvecs_pkg::PDC_UNUSED_LO && i <= tvecs_pkg::PDC_UNUSED_HI;
			tvecs_pkg::MODE_HDR1: isUnused = i >= tvecs_pkg::HDR_UNUSED_LO && i <= tvecs_pkg::HDR1_UNUSED_HI;
			tvecs_pkg::MODE_HDR2: isUnused = i >= tvecs_pkg::HDR_UNUSED_LO && i <= tvecs_pkg::HDR2_UNUSED_HI;
			tvecs_pkg::MODE_HDR3: isUnused = i >= tvecs_pkg::HDR_UNUSED_LO && i <= tvecs_pkg::HDR3_UNUSED_HI;
			default: begin
				if (m >= tvecs_pkg::MODE_STAT1 && m <= tvecs_pkg::MODE_STAT4) begin
					isUnused = i >= tvecs_pkg::STAT_UNUSED_LO &&
						i <= (m[0] ? tvecs_pkg::STAT24_UNUSED : tvecs_pkg::STAT13_UNUSED);
				end else begin
					isUnused = 1'b0;
				end
			end
		endcase
	endfunction

	// Mask lookup; a mask bit of 1 turns checking off and, unless globalCheckDisable is set, uncheckedByteHandling then decides the write.
	always_comb begin
		mapped = 1'b0;
		maskBit = 1'b0;
		// Header 1 is entry zero of the parity table, so the mode is rebased before it indexes.
		parOff = bus.byteIndex - tvecs_pkg::PAR_BASE[3'(bus.acqMode - tvecs_pkg::MODE_HDR1)];
		if (bus.acqMode == tvecs_pkg::MODE_VPS) begin
			if (bus.byteIndex == tvecs_pkg::VPS_BYTE_SOLO) begin
				mapped = 1'b1;
				maskBit = bus.biphMask[0];
			end else if (bus.byteIndex >= tvecs_pkg::VPS_MASK_LO && bus.byteIndex <= tvecs_pkg::VPS_MASK_HI) begin
				mapped = 1'b1;
				maskBit = bus.biphMask[3'(bus.byteIndex - tvecs_pkg::VPS_MASK_LO) + 3'h1];
			end
		end else if (bus.acqMode == tvecs_pkg::MODE_PDC) begin
			if (bus.byteIndex >= tvecs_pkg::PDC_MASK_LO && bus.byteIndex - tvecs_pkg::PDC_MASK_LO < tvecs_pkg::HAM_SPAN) begin
				mapped = 1'b1;
				maskBit = bus.hamMask[4'(bus.byteIndex - tvecs_pkg::PDC_MASK_LO)];
			end
		end else if (bus.acqMode >= tvecs_pkg::MODE_HDR1 && bus.acqMode <= tvecs_pkg::MODE_STAT4) begin
			if (parOff < tvecs_pkg::HAM_SPAN) begin
				mapped = 1'b1;
				maskBit = bus.hamMask[parOff[3:0]];
			end
		end
		unused = isUnused(bus.acqMode, bus.byteIndex);
		checkOn = mapped ? !maskBit : (unused ? !bus.unusedByteCheckOff : 1'b1);
		if (!bus.globalCheckDisable) begin
			writeD = checkOn ? !bus.byteError : bus.uncheckedByteHandling;
		end else begin
			writeD = (mapped && !maskBit) ? !bus.byteError : 1'b1;
		end
		errD = bus.byteError && !(!bus.globalCheckDisable && !checkOn && bus.uncheckedByteHandling &&
			bus.acqMode == tvecs_pkg::MODE_VPS);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus.outWrite <= 1'b0;
			bus.outError <= 1'b0;
			bus.outData <= 8'h00;
		end else begin
			bus.outWrite <= bus.byteValid && writeD;
			bus.outError <= bus.byteValid && errD;
			if (bus.byteValid) begin
				bus.outData <= bus.byteData;
			end
		end
	end

	hold_on_error_a: assert property (@(posedge clk) disable iff (!rst_n)
		bus.byteValid && !bus.globalCheckDisable && checkOn && bus.byteError |=> !bus.outWrite)
		else $error("errored checked byte was written");
	write_all_a: assert property (@(posedge clk) disable iff (!rst_n)
		bus.byteValid && bus.globalCheckDisable && !(mapped && !maskBit) |=> bus.outWrite)
		else $error("byte not written with checking disabled");
	unchecked_byte_a: assert property (@(posedge clk) disable iff (!rst_n)
		bus.byteValid && !bus.globalCheckDisable && !checkOn |=> bus.outWrite == $past(bus.uncheckedByteHandling))
		else $error("unchecked byte handling ignored");
	errored_write_c: cover property (@(posedge clk) disable iff (!rst_n) bus.outWrite && bus.outError);

endmodule

// ### src/tvecs_if.sv
// Settings and acquired-byte stream passed between the decoder and the byte gate.
`timescale 1ns/1ps
interface tvecs_if;
	logic        runinSel;
	logic        framingSel;
	logic        globalCheckDisable;
	logic        uncheckedByteHandling;
	logic        unusedByteCheckOff;
	logic [5:0]  biphMask;
	logic [12:0] hamMask;
	logic [3:0]  acqMode;
	logic        byteValid;
	logic [5:0]  byteIndex;
	logic        byteError;
	logic [7:0]  byteData;
	logic        outWrite;
	logic        outError;
	logic [7:0]  outData;

	modport cfg (output runinSel, framingSel, globalCheckDisable, uncheckedByteHandling, unusedByteCheckOff,
		biphMask, hamMask, acqMode, byteValid, byteIndex, byteError, byteData,
		input outWrite, outError, outData);
	modport gate (input runinSel, framingSel, globalCheckDisable, uncheckedByteHandling, unusedByteCheckOff,
		biphMask, hamMask, acqMode, byteValid, byteIndex, byteError, byteData,
		output outWrite, outError, outData);
endinterface

// ### src/tvecs_pkg.sv
// Constants, command codes and byte tables of the error-check setup block.
package tvecs_pkg;

	// First bytes of the four setup commands.
	localparam logic [7:0] CMD_DISC_MODE  = 8'hF6;
	localparam logic [7:0] CMD_BIPH_MASK  = 8'hF7;
	localparam logic [7:0] CMD_HAM_LOW    = 8'hF8;
	localparam logic [7:0] CMD_HAM_HIGH   = 8'hF9;

	// Byte framing on the serial command input.
	localparam int         BYTE_BITS      = 8;
	localparam int         ID_BIT         = 7;
	localparam logic [2:0] LAST_BIT_CNT   = 3'h7;

	// Field positions in the discrimination and error-mode settings byte.
	localparam int         RUNIN_POS      = 4;
	localparam int         FRAMING_POS    = 3;
	localparam int         GDIS_POS       = 2;
	localparam int         UNCH_POS       = 1;
	localparam int         UNUSED_POS     = 0;

	// Setting widths and reset values.
	localparam logic [4:0] DISC_RESET     = 5'h00;
	localparam logic [5:0] BIPH_RESET     = 6'h00;
	localparam logic [6:0] HAMLO_RESET    = 7'h00;
	localparam logic [5:0] HAMHI_RESET    = 6'h00;

	// Acquisition modes.
	localparam logic [3:0] MODE_VPS       = 4'h0;
	localparam logic [3:0] MODE_PDC       = 4'h1;
	localparam logic [3:0] MODE_HDR1      = 4'h4;
	localparam logic [3:0] MODE_HDR2      = 4'h5;
	localparam logic [3:0] MODE_HDR3      = 4'h6;
	localparam logic [3:0] MODE_STAT1     = 4'h8;
	localparam logic [3:0] MODE_STAT4     = 4'hB;

	// Byte numbers that the masks and the unused ranges refer to.
	localparam logic [5:0] VPS_BYTE_SOLO  = 6'h05;
	localparam logic [5:0] VPS_MASK_LO    = 6'h0B;
	localparam logic [5:0] VPS_MASK_HI    = 6'h0F;
	localparam logic [5:0] PDC_MASK_LO    = 6'h0D;
	localparam logic [5:0] HAM_SPAN       = 6'h0D;
	localparam logic [5:0] VPS_UNUSED_A   = 6'h03;
	localparam logic [5:0] VPS_UNUSED_B   = 6'h04;
	localparam logic [5:0] VPS_UNUSED_LO  = 6'h06;
	localparam logic [5:0] VPS_UNUSED_HI  = 6'h0A;
	localparam logic [5:0] PDC_UNUSED_LO  = 6'h07;
	localparam logic [5:0] PDC_UNUSED_HI  = 6'h0C;
	localparam logic [5:0] HDR_UNUSED_LO  = 6'h0E;
	localparam logic [5:0] HDR1_UNUSED_HI = 6'h25;
	localparam logic [5:0] HDR2_UNUSED_HI = 6'h1D;
	localparam logic [5:0] HDR3_UNUSED_HI = 6'h15;
	localparam logic [5:0] STAT_UNUSED_LO = 6'h07;
	localparam logic [5:0] STAT13_UNUSED  = 6'h19;
	localparam logic [5:0] STAT24_UNUSED  = 6'h23;

	// Parity byte checked by mask bit 0 in header 1..4 and status 1..4.
	localparam logic [5:0] PAR_BASE [8] = '{6'h26, 6'h16, 6'h1E, 6'h0E, 6'h1A, 6'h24, 6'h1A, 6'h24};

	typedef enum logic [2:0] {PEND_NONE, PEND_DISC, PEND_BIPH, PEND_HLO, PEND_HHI} tvecs_pend_e;

endpackage

// ### src/tvecs_top.sv
// Serial setup-command decoder holding the error-check settings.
`timescale 1ns/1ps
module tvecs_top (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Serial command input
	input  wire logic       cmdSclk,
	input  wire logic       serialCmdBits,
	input  wire logic       cmdSelect_n,
	// Acquired byte stream
	input  wire logic [3:0] acqMode,
	input  wire logic       acqByteValid,
	input  wire logic [5:0] acqByteIndex,
	input  wire logic       acqByteError,
	input  wire logic [7:0] acqByteData,
	// Readout buffer write port
	output logic            bufWrite,
	output logic            bufError,
	output logic [7:0]      bufData,
	// Discrimination selects
	output logic            runinDiscrimSel,
	output logic            framingDiscrimSel
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.
	////////////////////////////////////////////////////////////////////////////

	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic       sclkPrev_q;
	logic       sclkRise;
	logic       selActive;

	// Index 0 clock, 1 data, 2 select; stage one feeds only stage two.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= 3'h7;
			sync2_q <= 3'h7;
		end else begin
			sync1_q <= {cmdSelect_n, serialCmdBits, cmdSclk};
			sync2_q <= sync1_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclkPrev_q <= 1'b1;
		end else begin
			sclkPrev_q <= sync2_q[0];
		end
	end

	assign sclkRise = sync2_q[0] && !sclkPrev_q;
	assign selActive = !sync2_q[2];

	////////////////////////////////////////////////////////////////////////////
	// Byte assembly, most significant bit first.
	////////////////////////////////////////////////////////////////////////////

	logic [6:0] shift_q;
	logic [2:0] bitCnt_q;
	logic [7:0] byte_q;
	logic       byteDone_q;

	// Releasing the select drops a partial byte so the next frame starts aligned.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_q <= 7'h00;
			bitCnt_q <= 3'h0;
		end else if (!selActive) begin
			bitCnt_q <= 3'h0;
		end else if (sclkRise) begin
			shift_q <= {shift_q[5:0], sync2_q[1]};
			bitCnt_q <= bitCnt_q + 3'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			byte_q <= 8'h00;
			byteDone_q <= 1'b0;
		end else begin
			byteDone_q <= selActive && sclkRise && bitCnt_q == tvecs_pkg::LAST_BIT_CNT;
			if (selActive && sclkRise && bitCnt_q == tvecs_pkg::LAST_BIT_CNT) begin
				byte_q <= {shift_q, sync2_q[1]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command decoding.
	////////////////////////////////////////////////////////////////////////////

	function automatic tvecs_pkg::tvecs_pend_e cmdDecode(input logic [7:0] b);
		case (b)
			tvecs_pkg::CMD_DISC_MODE: cmdDecode = tvecs_pkg::PEND_DISC;
			tvecs_pkg::CMD_BIPH_MASK: cmdDecode = tvecs_pkg::PEND_BIPH;
			tvecs_pkg::CMD_HAM_LOW:   cmdDecode = tvecs_pkg::PEND_HLO;
			tvecs_pkg::CMD_HAM_HIGH:  cmdDecode = tvecs_pkg::PEND_HHI;
			default:                  cmdDecode = tvecs_pkg::PEND_NONE;
		endcase
	endfunction

	tvecs_pkg::tvecs_pend_e pend_q;
	logic                   isFirst;
	logic                   setWrite;

	assign isFirst = byte_q[tvecs_pkg::ID_BIT];
	assign setWrite = byteDone_q && !isFirst;

	// Other commands of the device also open with a set bit 7; they just cancel.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_q <= tvecs_pkg::PEND_NONE;
		end else if (byteDone_q) begin
			case (isFirst)
				1'b1:    pend_q <= cmdDecode(byte_q);
				default: pend_q <= tvecs_pkg::PEND_NONE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Setting registers.
	////////////////////////////////////////////////////////////////////////////

	logic [4:0] disc_q;
	logic [5:0] biph_q;
	logic [6:0] hamLo_q;
	logic [5:0] hamHi_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			disc_q <= tvecs_pkg::DISC_RESET;
		end else if (setWrite && pend_q == tvecs_pkg::PEND_DISC) begin
			disc_q <= byte_q[4:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			biph_q <= tvecs_pkg::BIPH_RESET;
		end else if (setWrite && pend_q == tvecs_pkg::PEND_BIPH) begin
			biph_q <= byte_q[5:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hamLo_q <= tvecs_pkg::HAMLO_RESET;
		end else if (setWrite && pend_q == tvecs_pkg::PEND_HLO) begin
			hamLo_q <= byte_q[6:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hamHi_q <= tvecs_pkg::HAMHI_RESET;
		end else if (setWrite && pend_q == tvecs_pkg::PEND_HHI) begin
			hamHi_q <= byte_q[5:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Byte gate.
	////////////////////////////////////////////////////////////////////////////

	tvecs_if link ();

	assign link.runinSel = disc_q[tvecs_pkg::RUNIN_POS];
	assign link.framingSel = disc_q[tvecs_pkg::FRAMING_POS];
	assign link.globalCheckDisable = disc_q[tvecs_pkg::GDIS_POS];
	assign link.uncheckedByteHandling = disc_q[tvecs_pkg::UNCH_POS];
	assign link.unusedByteCheckOff = disc_q[tvecs_pkg::UNUSED_POS];
	assign link.biphMask = biph_q;
	assign link.hamMask = {hamHi_q, hamLo_q};
	assign link.acqMode = acqMode;
	assign link.byteValid = acqByteValid;
	assign link.byteIndex = acqByteIndex;
	assign link.byteError = acqByteError;
	assign link.byteData = acqByteData;

	tvecs_byte_gate u_gate (
		.clk   (clk),
		.rst_n (rst_n),
		.bus   (link.gate)
	);

	assign bufWrite = link.outWrite;
	assign bufError = link.outError;
	assign bufData = link.outData;
	assign runinDiscrimSel = link.runinSel;
	assign framingDiscrimSel = link.framingSel;

	////////////////////////////////////////////////////////////////////////////
	// Checks on the setting registers.
	////////////////////////////////////////////////////////////////////////////

	disc_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		setWrite && pend_q == tvecs_pkg::PEND_DISC |=> disc_q == $past(byte_q[4:0]))
		else $error("discrimination settings not taken");

	biph_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		setWrite && pend_q == tvecs_pkg::PEND_BIPH |=> biph_q == $past(byte_q[5:0]))
		else $error("bi-phase mask not taken");

	hamlo_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		setWrite && pend_q == tvecs_pkg::PEND_HLO |=> hamLo_q == $past(byte_q[6:0]))
		else $error("low Hamming mask not taken");

	hamhi_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		setWrite && pend_q == tvecs_pkg::PEND_HHI |=> hamHi_q == $past(byte_q[5:0]))
		else $error("high Hamming mask not taken");

	first_byte_a: assert property (@(posedge clk) disable iff (!rst_n)
		byteDone_q && isFirst |=> $stable({disc_q, biph_q, hamLo_q, hamHi_q}))
		else $error("first byte changed a setting");

	orphan_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
		setWrite && pend_q == tvecs_pkg::PEND_NONE |=> $stable({disc_q, biph_q, hamLo_q, hamHi_q}) ##1
		pend_q == tvecs_pkg::PEND_NONE)
		else $error("orphan settings byte was used");

	discrim_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
		setWrite && pend_q == tvecs_pkg::PEND_DISC |=>
		runinDiscrimSel == $past(byte_q[4]) && framingDiscrimSel == $past(byte_q[3]))
		else $error("discrimination selects wrong");

	reset_clear_a: assert property (@(posedge clk)
		!rst_n |=> {disc_q, biph_q, hamLo_q, hamHi_q} == 24'h000000 || $past(rst_n))
		else $error("settings not cleared by reset");

	byte_frame_a: assert property (@(posedge clk) disable iff (!rst_n)
		byteDone_q |-> $past(bitCnt_q) == tvecs_pkg::LAST_BIT_CNT)
		else $error("byte completed off the eighth bit");

	disc_cmd_c: cover property (@(posedge clk) disable iff (!rst_n)
		setWrite && pend_q == tvecs_pkg::PEND_DISC);
	ham_cmd_c: cover property (@(posedge clk) disable iff (!rst_n)
		setWrite && pend_q == tvecs_pkg::PEND_HHI);
	orphan_c: cover property (@(posedge clk) disable iff (!rst_n)
		setWrite && pend_q == tvecs_pkg::PEND_NONE);
	parity_mode_c: cover property (@(posedge clk) disable iff (!rst_n)
		acqByteValid && acqMode >= tvecs_pkg::MODE_HDR1 ##1 bufWrite && bufError);

	////////////////////////////////////////////////////////////////////////////
	// Checks on the serial command path.
	////////////////////////////////////////////////////////////////////////////

	sel_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
		!selActive |=> bitCnt_q == 3'h0)
		else $error("partial byte kept after select release");

	bit_order_a: assert property (@(posedge clk) disable iff (!rst_n)
		byteDone_q |-> byte_q[0] == $past(sync2_q[1]))
		else $error("last serial bit not placed in bit zero");

	disc_pend_a: assert property (@(posedge clk) disable iff (!rst_n)
		byteDone_q && byte_q == tvecs_pkg::CMD_DISC_MODE |=> pend_q == tvecs_pkg::PEND_DISC)
		else $error("discrimination command not opened");

	biph_pend_a: assert property (@(posedge clk) disable iff (!rst_n)
		byteDone_q && byte_q == tvecs_pkg::CMD_BIPH_MASK |=> pend_q == tvecs_pkg::PEND_BIPH)
		else $error("bi-phase mask command not opened");

	hamlo_pend_a: assert property (@(posedge clk) disable iff (!rst_n)
		byteDone_q && byte_q == tvecs_pkg::CMD_HAM_LOW |=> pend_q == tvecs_pkg::PEND_HLO)
		else $error("low Hamming mask command not opened");

	hamhi_pend_a: assert property (@(posedge clk) disable iff (!rst_n)
		byteDone_q && byte_q == tvecs_pkg::CMD_HAM_HIGH |=> pend_q == tvecs_pkg::PEND_HHI)
		else $error("high Hamming mask command not opened");

	// Any byte outside the four command codes, settings bytes included, must leave nothing pending.
	pend_cancel_a: assert property (@(posedge clk) disable iff (!rst_n)
		byteDone_q && (byte_q < tvecs_pkg::CMD_DISC_MODE || byte_q > tvecs_pkg::CMD_HAM_HIGH) |=>
		pend_q == tvecs_pkg::PEND_NONE)
		else $error("pending command not cancelled");

	settings_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!setWrite |=> $stable({disc_q, biph_q, hamLo_q, hamHi_q}))
		else $error("setting changed without a settings byte");

	////////////////////////////////////////////////////////////////////////////
	// Checks on the readout path.
	////////////////////////////////////////////////////////////////////////////

	// These watch only pins and settings, so a broken mask lookup in the gate still trips them.
	write_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
		bufWrite |-> $past(acqByteValid))
		else $error("buffer write without an offered byte");

	error_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
		bufError |-> $past(acqByteValid && acqByteError))
		else $error("error bit without an errored byte");

	data_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
		acqByteValid |=> bufData == $past(acqByteData))
		else $error("offered byte not passed to the buffer");

	data_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!acqByteValid |=> $stable(bufData))
		else $error("buffer data moved between bytes");

	disabled_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		acqByteValid && link.globalCheckDisable && !acqByteError |=> bufWrite)
		else $error("clean byte held with checking disabled");

	vps_err_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		acqByteValid && acqMode == tvecs_pkg::MODE_VPS && acqByteIndex == tvecs_pkg::VPS_BYTE_SOLO &&
		biph_q[0] && !link.globalCheckDisable && link.uncheckedByteHandling |=> !bufError)
		else $error("error bit not cleared on a written VPS byte");

	vps_mask_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		acqByteValid && acqMode == tvecs_pkg::MODE_VPS && acqByteIndex == tvecs_pkg::VPS_MASK_HI &&
		!biph_q[5] && !link.globalCheckDisable && acqByteError |=> !bufWrite)
		else $error("errored byte 15 written with its check on");

	pdc_mask_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		acqByteValid && acqMode == tvecs_pkg::MODE_PDC && acqByteIndex == tvecs_pkg::PDC_MASK_LO &&
		hamLo_q[0] && !link.globalCheckDisable |=> bufWrite == $past(link.uncheckedByteHandling))
		else $error("unchecked byte 13 handling wrong");

	unused_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		acqByteValid && acqMode == tvecs_pkg::MODE_PDC && acqByteIndex == tvecs_pkg::PDC_UNUSED_LO &&
		!link.unusedByteCheckOff && !link.globalCheckDisable && acqByteError |=> !bufWrite)
		else $error("errored unused byte written with its check on");

endmodule
